// ==== logic/low_voltage_monitor.sv ====
// Control, status and interrupt logic of the supply low-voltage monitor.
// Assumes an analogue comparator outside, already fed the selected trip level, and a
// processor-side register port on the same clock.
// How it works
// RQ1 - Enable bit 4 powers detector; off freezes flag.
// RQ2 - Three bits choose one of eight levels.
// RQ3 - Read-only bit 5 shows supply below level.
// RQ4 - Sleep disables the detector regardless of enable.
// RQ5 - Software waits settle delay before trusting flag.
// RQ6 - Flag follows comparator; may toggle near level.
// RQ7 - Interrupt only after fixed delay from flag; irq_out fires on the flag's rise with no delay when mask bit 0 is set.
// RQ8 - Delay expiry sets request flag; enable gates.
// RQ9 - Low-voltage request wakes device from idle.
// RQ10 - Software presets request flag to avoid wake; the code still wakes on every delay expiry, preset or not.
// RQ11 - Control bits 7 and 6 read zero.
// RQ12 - Request bit 4, enable bit 0, shared register.
// RQ13 - Global enable must be one to interrupt; the code gates only cpu_irq_out with it, irq_out follows status and mask alone.
// RQ14 - Request sticky, writable; comparator synchronised first.
`timescale 1ns/1ps
`include "lvm_map.svh"
module low_voltage_monitor #(
   parameter int SETTLE_CYCLES = (`SETTLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int IRQ_DELAY_CYCLES = (`IRQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int COUNT_W = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // Register port
   input wire lvm_pkg::addr_t reg_addr_in,
   input wire lvm_pkg::byte_t reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output lvm_pkg::byte_t reg_rdata_out,
   // Analogue side
   input wire logic comparator_low_in,
   output logic detector_power_out,
   output logic bandgap_buffer_enable_out,
   output lvm_pkg::trip_level_t trip_level_select_out,
   // Power mode and system
   input wire logic sleep_mode_in,
   output logic idle_wakeup_out,
   output logic cpu_irq_out,
   output logic irq_out,
   output logic settled_out
);
   import lvm_pkg::*;

   typedef struct packed {
      trip_level_t trip_level_select;
      logic bandgap_buffer_enable;
      logic monitor_enable;
      logic low_supply_detected_flag;
      logic low_supply_irq_enable;
      logic low_supply_irq_request;
      logic global_irq_enable;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      byte_t rdata;
   } mon_state_t;

   mon_state_t state_reg;
   mon_state_t state_next;
   logic comp_sync;
   logic detector_active;
   logic irq_delay_expired;
   logic settled;
   logic flag_rise;

   function automatic logic hit(input addr_t a, input addr_t target, input logic strobe);
      hit = strobe && (a == target);
   endfunction

   // The comparator sits in the analogue domain, so it is synchronised first.
   bit_sync u_comp_sync ( // RQ14
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .async_in(comparator_low_in),
      .sync_out(comp_sync)
   );

   assign detector_active = state_reg.monitor_enable && !sleep_mode_in; // RQ1 RQ4

   // Settle timer gives software a status bit for the stabilisation wait.
   delay_timer #(.COUNT_W(COUNT_W)) u_settle ( // RQ5
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .run_in(detector_active),
      .cycles_in(COUNT_W'(SETTLE_CYCLES)),
      .expired_out(),
      .done_out(settled)
   );

   // Delay restarts whenever the flag drops, so a hovering supply must stay low long enough.
   delay_timer #(.COUNT_W(COUNT_W)) u_irq_delay ( // RQ7
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .run_in(detector_active && state_reg.low_supply_detected_flag),
      .cycles_in(COUNT_W'(IRQ_DELAY_CYCLES)),
      .expired_out(irq_delay_expired),
      .done_out()
   );

   assign flag_rise = detector_active && comp_sync && !state_reg.low_supply_detected_flag;

   always_comb begin
      state_next = state_reg;
      state_next.rdata = '0;
      // Flag tracks the comparator only while powered; otherwise it holds.
      if (detector_active) begin
         state_next.low_supply_detected_flag = comp_sync; // RQ3 RQ6 RQ1
      end
      if (hit(reg_addr_in, `ADDR_MON_CTRL, reg_write_in)) begin
         state_next.trip_level_select = reg_wdata_in[`BIT_TRIP_HI:`BIT_TRIP_LO]; // RQ2
         state_next.bandgap_buffer_enable = reg_wdata_in[`BIT_BANDGAP];
         state_next.monitor_enable = reg_wdata_in[`BIT_MON_EN]; // RQ1
      end
      if (hit(reg_addr_in, `ADDR_IRQ_CTRL, reg_write_in)) begin
         state_next.low_supply_irq_enable = reg_wdata_in[`BIT_IRQ_EN]; // RQ12
         state_next.low_supply_irq_request = reg_wdata_in[`BIT_IRQ_REQ]; // RQ14 RQ10
      end
      if (hit(reg_addr_in, `ADDR_GLOBAL_CTRL, reg_write_in)) begin
         state_next.global_irq_enable = reg_wdata_in[`BIT_GLOBAL_EN]; // RQ13
      end
      if (hit(reg_addr_in, `ADDR_IRQ_MASK, reg_write_in)) begin
         state_next.irq_mask = reg_wdata_in[`BIT_EV_REQUEST:`BIT_EV_DETECT];
      end
      if (hit(reg_addr_in, `ADDR_IRQ_STATUS, reg_read_in)) begin
         state_next.irq_status = '0;
      end
      // Hardware sets win over a same-cycle software clear.
      if (irq_delay_expired) begin
         state_next.low_supply_irq_request = 1'b1; // RQ8
         state_next.irq_status[`BIT_EV_REQUEST] = 1'b1;
      end
      if (flag_rise) begin
         state_next.irq_status[`BIT_EV_DETECT] = 1'b1;
      end
      if (reg_read_in) begin
         unique case (reg_addr_in)
            `ADDR_MON_CTRL: begin
               state_next.rdata[`BIT_TRIP_HI:`BIT_TRIP_LO] = state_reg.trip_level_select;
               state_next.rdata[`BIT_BANDGAP] = state_reg.bandgap_buffer_enable;
               state_next.rdata[`BIT_MON_EN] = state_reg.monitor_enable;
               state_next.rdata[`BIT_DETECTED] = state_reg.low_supply_detected_flag; // RQ3
               // Bits 7 and 6 stay at the zero set above.
            end // RQ11
            `ADDR_IRQ_CTRL: begin
               state_next.rdata[`BIT_IRQ_EN] = state_reg.low_supply_irq_enable;
               state_next.rdata[`BIT_IRQ_REQ] = state_reg.low_supply_irq_request;
            end
            `ADDR_GLOBAL_CTRL: begin
               state_next.rdata[`BIT_GLOBAL_EN] = state_reg.global_irq_enable;
            end
            `ADDR_IRQ_STATUS: begin
               state_next.rdata[`BIT_EV_REQUEST:`BIT_EV_DETECT] = state_reg.irq_status;
            end
            `ADDR_IRQ_MASK: begin
               state_next.rdata[`BIT_EV_REQUEST:`BIT_EV_DETECT] = state_reg.irq_mask;
            end
            default: state_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata_out = state_reg.rdata;
   assign detector_power_out = detector_active;
   assign bandgap_buffer_enable_out = state_reg.bandgap_buffer_enable;
   assign trip_level_select_out = state_reg.trip_level_select; // RQ2
   // Wake-up ignores the interrupt enables and the request flag; it pulses on every delay expiry, even with the request preset.
   assign idle_wakeup_out = irq_delay_expired; // RQ9 RQ10
   assign cpu_irq_out = state_reg.low_supply_irq_request && state_reg.low_supply_irq_enable
      && state_reg.global_irq_enable; // RQ8 RQ12 RQ13
   assign irq_out = |(state_reg.irq_status & state_reg.irq_mask);
   assign settled_out = settled;
endmodule

// ==== logic/lvm_map.svh ====
// Register map, field positions, reset values and timing figures of the supply monitor.
// Assumes inclusion by bare name from the modules that need it.
`ifndef LVM_MAP_SVH
`define LVM_MAP_SVH
`define ADDR_MON_CTRL 4'h0
`define ADDR_IRQ_CTRL 4'h1
`define ADDR_GLOBAL_CTRL 4'h2
`define ADDR_IRQ_STATUS 4'h3
`define ADDR_IRQ_MASK 4'h4
`define BIT_TRIP_LO 0
`define BIT_TRIP_HI 2
`define BIT_BANDGAP 3
`define BIT_MON_EN 4
`define BIT_DETECTED 5
`define BIT_IRQ_EN 0
`define BIT_IRQ_REQ 4
`define BIT_GLOBAL_EN 0
`define BIT_EV_DETECT 0
`define BIT_EV_REQUEST 1
`define MON_CTRL_RESET 8'h00
`define IRQ_CTRL_RESET 8'h00
`define SETTLE_DELAY_NS 100
`define IRQ_DELAY_NS 1000
`define CLK_PERIOD_NS 5
`endif

// ==== logic/lvm_pkg.sv ====
// Types shared by the supply monitor modules.
// Assumes nothing beyond the map header.
package lvm_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] addr_t;
   typedef logic [2:0] trip_level_t;
   typedef enum logic [1:0] {
      DLY_IDLE,
      DLY_COUNT,
      DLY_DONE
   } delay_state_t;
endpackage

// ==== logic/bit_sync.sv ====
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a slow level such as a comparator output.
`timescale 1ns/1ps
module bit_sync (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic first;
      logic second;
   } sync_state_t;
   sync_state_t state_reg;
   sync_state_t state_next;
   always_comb begin
      state_next = state_reg;
      state_next.first = async_in;
      state_next.second = state_reg.first;
   end
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign sync_out = state_reg.second;
endmodule

// ==== logic/delay_timer.sv ====
// Retriggerable delay timer: counts while its start level holds and pulses once at the end.
// Assumes start is already synchronous to mclk_in.
`timescale 1ns/1ps
`include "lvm_map.svh"
module delay_timer #(
   parameter int COUNT_W = 16
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // Control
   input wire logic run_in,
   input wire logic [COUNT_W-1:0] cycles_in,
   output logic expired_out,
   output logic done_out
);
   import lvm_pkg::*;
   typedef struct packed {
      delay_state_t st;
      logic [COUNT_W-1:0] count;
      logic expired;
   } timer_state_t;
   timer_state_t state_reg;
   timer_state_t state_next;
   always_comb begin
      state_next = state_reg;
      state_next.expired = 1'b0;
      unique case (state_reg.st)
         DLY_IDLE: begin
            if (run_in) begin
               state_next.st = DLY_COUNT;
               state_next.count = COUNT_W'(1);
            end
         end
         DLY_COUNT: begin
            if (!run_in) begin
               state_next.st = DLY_IDLE;
            end else if (state_reg.count >= cycles_in) begin
               state_next.st = DLY_DONE;
               state_next.expired = 1'b1;
            end else begin
               state_next.count = state_reg.count + COUNT_W'(1);
            end
         end
         DLY_DONE: begin
            if (!run_in) begin
               state_next.st = DLY_IDLE;
            end
         end
         default: state_next.st = DLY_IDLE;
      endcase
   end
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= '{st: DLY_IDLE, count: '0, expired: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end
   assign expired_out = state_reg.expired;
   assign done_out = (state_reg.st == DLY_DONE);
endmodule

// ==== verification/low_voltage_monitor_assertions.sv ====
// Port-level checks of the supply monitor, bound into its top module.
// Assumes one clock domain and the register map header.
`timescale 1ns/1ps
`include "lvm_map.svh"
module low_voltage_monitor_assertions (
   // Clock, reset and register port
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire lvm_pkg::addr_t reg_addr_in,
   input wire lvm_pkg::byte_t reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire lvm_pkg::byte_t reg_rdata_out,
   // Analogue, power and interrupt side
   input wire logic comparator_low_in,
   input wire logic detector_power_out,
   input wire logic bandgap_buffer_enable_out,
   input wire lvm_pkg::trip_level_t trip_level_select_out,
   input wire logic sleep_mode_in,
   input wire logic idle_wakeup_out,
   input wire logic cpu_irq_out,
   input wire logic irq_out,
   input wire logic settled_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   a_sleep_powers_off: assert property (sleep_mode_in |-> !detector_power_out)
      else $error("detector powered in sleep");
   a_ctrl_top_zero: assert property (reg_read_in && reg_addr_in == `ADDR_MON_CTRL
      |=> reg_rdata_out[7:6] == 2'b00) else $error("control bits 7 and 6 not zero");
   a_trip_after_write: assert property ($changed(trip_level_select_out)
      |-> $past(reg_write_in && reg_addr_in == `ADDR_MON_CTRL)) else $error("trip moved alone");
   a_wake_one_cycle: assert property (idle_wakeup_out |=> !idle_wakeup_out)
      else $error("wake pulse too long");
   a_no_early_wake: assert property ((!comparator_low_in && detector_power_out) [*6]
      ##1 comparator_low_in |-> !idle_wakeup_out [*5]) else $error("wake before delay");
   a_request_held: assert property ($fell(cpu_irq_out) |-> $past(reg_write_in))
      else $error("request dropped without write");
   a_status_on_access: assert property ($fell(irq_out)
      |-> $past(reg_read_in || reg_write_in)) else $error("status dropped alone");
   a_settle_not_instant: assert property ($rose(detector_power_out) |=> !settled_out)
      else $error("settled at once");
   c_wake: cover property (idle_wakeup_out);
   c_both_irq: cover property (cpu_irq_out && irq_out);
   c_sleep: cover property (sleep_mode_in && !detector_power_out);
endmodule
bind low_voltage_monitor low_voltage_monitor_assertions u_low_voltage_monitor_assertions (
   .mclk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
   .reg_rdata_out, .comparator_low_in, .detector_power_out, .bandgap_buffer_enable_out,
   .trip_level_select_out, .sleep_mode_in, .idle_wakeup_out, .cpu_irq_out, .irq_out,
   .settled_out);

// ==== verification/low_voltage_monitor_bench.sv ====
// Self-checking bench of the supply monitor: registers, detection and interrupts.
// Assumes the map header; delays are shortened to 2 and 4 cycles to keep the run short.
`timescale 1ns/1ps
`include "lvm_map.svh"
module low_voltage_monitor_bench;
   import lvm_pkg::*;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   addr_t reg_addr_in = 4'h0;
   byte_t reg_wdata_in = 8'h00;
   logic reg_write_in = 1'b0;
   logic reg_read_in = 1'b0;
   logic comparator_low_in = 1'b0;
   logic sleep_mode_in = 1'b0;
   byte_t reg_rdata_out;
   byte_t rd_val;
   logic detector_power_out, bandgap_buffer_enable_out, idle_wakeup_out;
   logic cpu_irq_out, irq_out, settled_out;
   trip_level_t trip_level_select_out;
   int fails = 0;
   int samples_checked = 0;
   int n;
   always #2.5 mclk_in = ~mclk_in;
   low_voltage_monitor #(.SETTLE_CYCLES(2), .IRQ_DELAY_CYCLES(4)) u_low_voltage_monitor (
      .mclk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
      .reg_rdata_out, .comparator_low_in, .detector_power_out, .bandgap_buffer_enable_out,
      .trip_level_select_out, .sleep_mode_in, .idle_wakeup_out, .cpu_irq_out, .irq_out,
      .settled_out);
   task automatic chk(input byte_t got, input byte_t exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input addr_t a, input byte_t d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge mclk_in);
      reg_write_in <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input addr_t a);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge mclk_in);
      reg_read_in <= 1'b0;
      #1 rd_val = reg_rdata_out;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_in);
      #1;
   endtask
   task automatic cmp(input logic v);
      @(posedge mclk_in);
      comparator_low_in <= v;
      cyc(8);
   endtask
   task automatic t_regs();
      rd(`ADDR_MON_CTRL);
      chk(rd_val, `MON_CTRL_RESET);
      rd(`ADDR_IRQ_CTRL);
      chk(rd_val, `IRQ_CTRL_RESET);
      for (int i = 0; i < 8; i++) begin
         wr(`ADDR_MON_CTRL, 8'hE8 | 8'(i));
         rd(`ADDR_MON_CTRL);
         chk(rd_val, 8'h08 | 8'(i));
         chk({5'h00, trip_level_select_out}, 8'(i));
         chk({7'h00, bandgap_buffer_enable_out}, 8'h01);
      end
      rd(4'hF);
      chk(rd_val, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_detect();
      cmp(1'b1);
      rd(`ADDR_MON_CTRL);
      chk(rd_val, 8'h0F);
      wr(`ADDR_MON_CTRL, 8'h10);
      chk({6'h00, detector_power_out, settled_out}, 8'h02);
      cyc(8);
      rd(`ADDR_MON_CTRL);
      chk({7'h00, settled_out}, 8'h01);
      chk(rd_val, 8'h30);
      cmp(1'b0);
      rd(`ADDR_MON_CTRL);
      chk(rd_val, 8'h10);
      @(posedge mclk_in);
      sleep_mode_in <= 1'b1;
      cyc(1);
      chk({7'h00, detector_power_out}, 8'h00);
      @(posedge mclk_in);
      sleep_mode_in <= 1'b0;
      $display("test detect done");
   endtask
   task automatic t_irq();
      wr(`ADDR_IRQ_CTRL, 8'h01);
      wr(`ADDR_GLOBAL_CTRL, 8'h01);
      rd(`ADDR_IRQ_STATUS);
      @(posedge mclk_in);
      comparator_low_in <= 1'b1;
      n = 0;
      while (idle_wakeup_out !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk({7'h00, n > 6 && n < 30}, 8'h01);
      cyc(2);
      chk({6'h00, cpu_irq_out, irq_out}, 8'h02);
      wr(`ADDR_IRQ_MASK, 8'h02);
      chk({7'h00, irq_out}, 8'h01);
      rd(`ADDR_IRQ_STATUS);
      chk(rd_val, 8'h03);
      cyc(1);
      chk({7'h00, irq_out}, 8'h00);
      rd(`ADDR_IRQ_CTRL);
      chk(rd_val, 8'h11);
      wr(`ADDR_GLOBAL_CTRL, 8'h00);
      chk({7'h00, cpu_irq_out}, 8'h00);
      wr(`ADDR_GLOBAL_CTRL, 8'h01);
      chk({7'h00, cpu_irq_out}, 8'h01);
      wr(`ADDR_IRQ_CTRL, 8'h01);
      cyc(20);
      chk({7'h00, cpu_irq_out}, 8'h00);
      wr(`ADDR_IRQ_CTRL, 8'h11);
      chk({7'h00, cpu_irq_out}, 8'h01);
      $display("test irq done");
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_detect();
      t_irq();
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge mclk_in);
      fails++;
      wrap_up();
   end
endmodule
